// file: rtl/adc_pkg.sv
package adc_pkg;

  // ----------------------------------------------------------------
  // Register page and offsets
  // ----------------------------------------------------------------
  localparam logic [3:0]  PAGE_AUDIO        = 4'h2;
  localparam logic [5:0]  OFS_FORMAT_RATE   = 6'h00;
  localparam logic [5:0]  OFS_RSVD_A        = 6'h01;
  localparam logic [5:0]  OFS_VOLUME        = 6'h02;
  localparam logic [5:0]  OFS_RSVD_B        = 6'h03;

  // ----------------------------------------------------------------
  // Reset values, write mask and gain codes
  // ----------------------------------------------------------------
  localparam logic [15:0] RST_FORMAT_RATE   = 16'h0000;
  localparam logic [15:0] RST_RSVD_A        = 16'hff00;
  localparam logic [15:0] RST_VOLUME        = 16'hffff;
  localparam logic [15:0] RST_RSVD_B        = 16'h8b00;
  localparam logic [15:0] FMT_WRITE_MASK    = 16'h0f3f;
  localparam logic [6:0]  ATT_ZERO_DB       = 7'h7f;
  localparam logic [6:0]  ATT_FLOOR         = 7'h00;
  localparam logic [7:0]  GAIN_MAX_STEPS    = 8'h7f;

  // ----------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------
  localparam int POS_WIDTH   = 10;
  localparam int POS_FORMAT  = 8;
  localparam int POS_RATE    = 0;
  localparam int POS_LMUTE   = 15;
  localparam int POS_LATT    = 8;
  localparam int POS_RMUTE   = 7;
  localparam int POS_RATT    = 0;

  // ----------------------------------------------------------------
  // Rate codes and base rates
  // ----------------------------------------------------------------
  localparam logic [5:0] RATE_DIV1   = 6'h00;
  localparam logic [5:0] RATE_DIV1P5 = 6'h09;
  localparam logic [5:0] RATE_DIV2   = 6'h12;
  localparam logic [5:0] RATE_DIV3   = 6'h1b;
  localparam logic [5:0] RATE_DIV4   = 6'h24;
  localparam logic [5:0] RATE_DIV5   = 6'h2d;
  localparam logic [5:0] RATE_DIV6A  = 6'h36;
  localparam logic [5:0] RATE_DIV6B  = 6'h3f;
  localparam logic [19:0] BASE_48K_HZ  = 20'd48000;
  localparam logic [19:0] BASE_44K1_HZ = 20'd44100;

  typedef enum logic [1:0] {W16, W20, W24, W32} adc_width_type;
  typedef enum logic [1:0] {F_I2S, F_DSP, F_RJ, F_LJ} adc_format_type;

  typedef struct packed {
    logic        wr;
    logic        rd;
    logic [3:0]  page;
    logic [5:0]  addr;
    logic [15:0] wdata;
  } adc_req_type;

  typedef struct packed {
    logic [5:0]     sample_bits;
    adc_format_type frame_format;
    logic [3:0]     div_x2;
    logic           rate_valid;
    logic [19:0]    sample_rate_hz;
  } adc_fmt_type;

  typedef struct packed {
    logic       mute;
    logic [6:0] att_code;
    logic [7:0] gain_steps;
    logic       settled;
  } adc_chan_type;

endpackage : adc_pkg

// file: rtl/adc_rate_decode.sv
`timescale 1ns/1ns
module adc_rate_decode import adc_pkg::*; (
  // Codes
  input  wire logic [1:0]  sample_width_sel,
  input  wire logic [1:0]  frame_format_sel,
  input  wire logic [5:0]  rate_divider_sel,
  input  wire logic        base_rate_sel,
  // Decoded
  output adc_fmt_type      fmt
);
  logic [19:0] base_hz;

  always_comb begin
    fmt = '0;
    case (sample_width_sel)
      W16:     fmt.sample_bits = 6'd16;
      W20:     fmt.sample_bits = 6'd20;
      W24:     fmt.sample_bits = 6'd24;
      default: fmt.sample_bits = 6'd32;
    endcase
    fmt.frame_format = adc_format_type'(frame_format_sel);
    base_hz = base_rate_sel ? BASE_44K1_HZ : BASE_48K_HZ;
    fmt.rate_valid = 1'b1;
    case (rate_divider_sel)
      RATE_DIV1:   fmt.div_x2 = 4'd2;
      RATE_DIV1P5: fmt.div_x2 = 4'd3;
      RATE_DIV2:   fmt.div_x2 = 4'd4;
      RATE_DIV3:   fmt.div_x2 = 4'd6;
      RATE_DIV4:   fmt.div_x2 = 4'd8;
      RATE_DIV5:   fmt.div_x2 = 4'd10;
      RATE_DIV6A:  fmt.div_x2 = 4'd12;
      RATE_DIV6B:  fmt.div_x2 = 4'd12;
      default: begin
        // Forbidden code: flagged, rate held at base
        fmt.div_x2 = 4'd2;
        fmt.rate_valid = 1'b0;
      end
    endcase
    fmt.sample_rate_hz = 20'((base_hz * 20'd2) / {16'd0, fmt.div_x2});
  end
endmodule : adc_rate_decode

// file: rtl/adc_gain_step.sv
`timescale 1ns/1ns
module adc_gain_step import adc_pkg::*; (
  // Clock and reset
  input  wire logic       clk,
  input  wire logic       nrst,
  input  wire logic       ce,
  // Control
  input  wire logic       step_tick,
  input  wire logic [6:0] att_code,
  // Applied gain in half-dB attenuation steps
  output logic [7:0]      gain_steps_ff,
  output logic            settled_ff
);
  logic [7:0] target;

  // Code 0 is the floor, 7f is 0 dB, others count half-dB steps
  always_comb begin
    if (att_code == ATT_FLOOR) begin
      target = GAIN_MAX_STEPS;
    end else if (att_code == ATT_ZERO_DB) begin
      target = 8'h00;
    end else begin
      target = {1'b0, att_code};
    end
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      gain_steps_ff <= 8'h00;
      settled_ff    <= 1'b1;
    end else if (ce) begin
      if (step_tick && gain_steps_ff < target) begin
        gain_steps_ff <= gain_steps_ff + 8'h01;
      end else if (step_tick && gain_steps_ff > target) begin
        gain_steps_ff <= gain_steps_ff - 8'h01;
      end
      settled_ff <= (gain_steps_ff == target);
    end
  end
endmodule : adc_gain_step

// file: rtl/adc_ctrl_regs.sv
`timescale 1ns/1ns
// Functional notes
// - Width field picks 16, 20, 24 or 32 bit samples.
// - Format field picks I2S, DSP, right or left justified.
// - Six-bit rate code divides base rate by 1 to 6.
// - Base rate is 48 kHz or 44.1 kHz.
// - Base rate bit: 0 gives 48 kHz, 1 gives 44.1 kHz.
// - Left mute bit silences left channel, resets set.
// - Left seven-bit code attenuates half dB per count, resets 0 dB.
// - Right mute bit silences right channel, resets set.
// - Right seven-bit code maps like left.
// - Applied gain steps 0.5 dB per frame clock, or every second.
// - Registers sit on page two, offsets 0 to 3.
module adc_ctrl_regs import adc_pkg::*; (
  // Clock and reset
  input  wire logic         clk,
  input  wire logic         nrst,
  input  wire logic         ce,
  // Host control port
  input  adc_req_type       req,
  output logic [15:0]       rdata_ff,
  output logic              rvalid_ff,
  // Neighbouring controls
  input  wire logic         base_rate_sel,
  input  wire logic         gain_step_rate_sel,
  input  wire logic         frame_clock,
  // Decoded settings
  output adc_fmt_type       fmt_ff,
  output adc_chan_type      left_ff,
  output adc_chan_type      right_ff,
  output logic              bad_rate_ff
);

  // ----------------------------------------------------------------
  // Storage
  // ----------------------------------------------------------------
  logic [15:0]  format_rate_ff;
  logic [15:0]  volume_ff;
  logic         hit;
  adc_fmt_type  fmt;
  logic         base_s1_ff, base_s2_ff;
  logic         step_s1_ff, step_s2_ff;
  logic         fclk_s1_ff, fclk_s2_ff, fclk_d_ff;
  logic         half_ff;
  logic         step_tick;
  logic [7:0]   lgain, rgain;
  logic         lset, rset;
  logic [15:0]  nxt_rdata;

  assign hit = (req.page == PAGE_AUDIO);

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      format_rate_ff <= RST_FORMAT_RATE;
    end else if (ce && req.wr && hit && req.addr == OFS_FORMAT_RATE) begin
      // Reserved bits forced to zero whatever is written
      format_rate_ff <= req.wdata & FMT_WRITE_MASK;
    end
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      volume_ff <= RST_VOLUME;
    end else if (ce && req.wr && hit && req.addr == OFS_VOLUME) begin
      volume_ff <= req.wdata;
    end
  end

  // ----------------------------------------------------------------
  // Pin synchronisers
  // ----------------------------------------------------------------
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      base_s1_ff <= 1'b0;
      base_s2_ff <= 1'b0;
      step_s1_ff <= 1'b0;
      step_s2_ff <= 1'b0;
      fclk_s1_ff <= 1'b0;
      fclk_s2_ff <= 1'b0;
      fclk_d_ff  <= 1'b0;
    end else if (ce) begin
      base_s1_ff <= base_rate_sel;
      base_s2_ff <= base_s1_ff;
      step_s1_ff <= gain_step_rate_sel;
      step_s2_ff <= step_s1_ff;
      fclk_s1_ff <= frame_clock;
      fclk_s2_ff <= fclk_s1_ff;
      fclk_d_ff  <= fclk_s2_ff;
    end
  end

  // ----------------------------------------------------------------
  // Soft-step pacing
  // ----------------------------------------------------------------
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      half_ff <= 1'b0;
    end else if (ce && fclk_s2_ff && !fclk_d_ff) begin
      half_ff <= ~half_ff;
    end
  end

  // Every second frame when slow stepping is selected
  assign step_tick = fclk_s2_ff && !fclk_d_ff && (!step_s2_ff || half_ff);

  // ----------------------------------------------------------------
  // Decode and gain
  // ----------------------------------------------------------------
  adc_rate_decode u_dec (
    .sample_width_sel (format_rate_ff[POS_WIDTH +: 2]),
    .frame_format_sel (format_rate_ff[POS_FORMAT +: 2]),
    .rate_divider_sel (format_rate_ff[POS_RATE +: 6]),
    .base_rate_sel    (base_s2_ff),
    .fmt              (fmt)
  );

  adc_gain_step u_left (
    .clk           (clk),
    .nrst          (nrst),
    .ce            (ce),
    .step_tick     (step_tick),
    .att_code      (volume_ff[POS_LATT +: 7]),
    .gain_steps_ff (lgain),
    .settled_ff    (lset)
  );

  adc_gain_step u_right (
    .clk           (clk),
    .nrst          (nrst),
    .ce            (ce),
    .step_tick     (step_tick),
    .att_code      (volume_ff[POS_RATT +: 7]),
    .gain_steps_ff (rgain),
    .settled_ff    (rset)
  );

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      fmt_ff      <= '0;
      bad_rate_ff <= 1'b0;
      left_ff     <= '0;
      right_ff    <= '0;
    end else if (ce) begin
      fmt_ff      <= fmt;
      bad_rate_ff <= !fmt.rate_valid;
      left_ff     <= '{mute: volume_ff[POS_LMUTE], att_code: volume_ff[POS_LATT +: 7],
                       gain_steps: lgain, settled: lset};
      right_ff    <= '{mute: volume_ff[POS_RMUTE], att_code: volume_ff[POS_RATT +: 7],
                       gain_steps: rgain, settled: rset};
    end
  end

  // ----------------------------------------------------------------
  // Read path
  // ----------------------------------------------------------------
  always_comb begin
    nxt_rdata = 16'h0000;
    if (hit) begin
      case (req.addr)
        OFS_FORMAT_RATE: nxt_rdata = format_rate_ff;
        OFS_RSVD_A:      nxt_rdata = RST_RSVD_A;
        OFS_VOLUME:      nxt_rdata = volume_ff;
        OFS_RSVD_B:      nxt_rdata = RST_RSVD_B;
        default:         nxt_rdata = 16'h0000;
      endcase
    end
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      rdata_ff  <= 16'h0000;
      rvalid_ff <= 1'b0;
    end else if (ce) begin
      rvalid_ff <= req.rd;
      if (req.rd) begin
        rdata_ff <= nxt_rdata;
      end
    end
  end

endmodule : adc_ctrl_regs

// file: dv/adc_ctrl_regs_assertions.sv
`timescale 1ns/1ns
module adc_ctrl_regs_checker import adc_pkg::*; (
  // Clock and reset
  input wire logic        clk,
  input wire logic        nrst,
  input wire logic        ce,
  // Host port
  input adc_req_type      req,
  input wire logic [15:0] rdata_ff,
  input wire logic        rvalid_ff,
  // Pins
  input wire logic        base_rate_sel,
  input wire logic        gain_step_rate_sel,
  input wire logic        frame_clock,
  // Decoded
  input adc_fmt_type      fmt_ff,
  input adc_chan_type     left_ff,
  input adc_chan_type     right_ff,
  input wire logic        bad_rate_ff
);
  // ----------
  // Checks
  // ----------
  default clocking cb @(posedge clk); endclocking
  default disable iff (!nrst);
  logic rd2;
  logic wf;
  logic wv;
  assign rd2 = ce && req.rd && req.page == PAGE_AUDIO;
  assign wf  = ce && req.wr && req.page == PAGE_AUDIO && req.addr == OFS_FORMAT_RATE;
  assign wv  = ce && req.wr && req.page == PAGE_AUDIO && req.addr == OFS_VOLUME;
  a_read_answer: assert property (ce && req.rd |=> rvalid_ff)
    else $error("read not answered");
  a_rvalid_pulse: assert property (ce && !req.rd |=> !rvalid_ff)
    else $error("read valid held");
  a_rsvd_a_value: assert property (
    rd2 && req.addr == OFS_RSVD_A |=> rdata_ff == 16'hff00) else $error("word a readback");
  a_rsvd_b_value: assert property (
    rd2 && req.addr == OFS_RSVD_B |=> rdata_ff == 16'h8b00) else $error("word b readback");
  a_fmt_zero_bits: assert property (rd2 && req.addr == OFS_FORMAT_RATE |=>
    rdata_ff[15:12] == 4'h0 && rdata_ff[7:6] == 2'h0) else $error("reserved bits set");
  a_unmapped_zero: assert property (
    ce && req.rd && (req.page != PAGE_AUDIO || req.addr > 6'h03) |=> rdata_ff == 16'h0000)
    else $error("unmapped read");
  a_width_format: assert property (wf |-> ##2
    fmt_ff.frame_format == $past(req.wdata[9:8], 2)
    && fmt_ff.sample_bits == ($past(req.wdata[11:10], 2) == 2'h3 ? 6'h20
    : 6'h10 + {2'h0, $past(req.wdata[11:10], 2), 2'h0})) else $error("width or format");
  a_rate_check: assert property (wf |-> ##2
    bad_rate_ff == ($past(req.wdata[5:3], 2) != $past(req.wdata[2:0], 2))) else $error("rate code");
  a_base_rate: assert property (($stable(base_rate_sel) && fmt_ff.rate_valid
    && fmt_ff.div_x2 == 4'h2)[*6] |->
    fmt_ff.sample_rate_hz == (base_rate_sel ? 20'hac44 : 20'hbb80)) else $error("base rate");
  a_volume_fields: assert property (wv |-> ##2
    left_ff.mute == $past(req.wdata[15], 2)
    && left_ff.att_code == $past(req.wdata[14:8], 2) && right_ff.mute == $past(req.wdata[7], 2)
    && right_ff.att_code == $past(req.wdata[6:0], 2)) else $error("volume fields");
  a_gain_step: assert property ($changed(left_ff.gain_steps) |->
    left_ff.gain_steps == $past(left_ff.gain_steps) + 8'h01
    || left_ff.gain_steps == $past(left_ff.gain_steps) - 8'h01) else $error("gain jump");
endmodule : adc_ctrl_regs_checker

bind adc_ctrl_regs adc_ctrl_regs_checker u_chk (.clk(clk), .nrst(nrst), .ce(ce), .req(req),
  .rdata_ff(rdata_ff), .rvalid_ff(rvalid_ff), .base_rate_sel(base_rate_sel),
  .gain_step_rate_sel(gain_step_rate_sel), .frame_clock(frame_clock), .fmt_ff(fmt_ff),
  .left_ff(left_ff), .right_ff(right_ff), .bad_rate_ff(bad_rate_ff));

// file: dv/audio_dac_control_regs_tb_top.sv
`timescale 1ns/1ns
module audio_dac_control_regs_tb_top import adc_pkg::*; ;
  logic         clk, nrst, ce, base_rate_sel, gain_step_rate_sel, frame_clock;
  logic         rvalid_ff, bad_rate_ff;
  logic [15:0]  rdata_ff;
  adc_req_type  req;
  adc_fmt_type  fmt_ff;
  adc_chan_type left_ff, right_ff;
  int           mismatches, comparisons;
  logic [5:0]   codes [9] = '{6'h00, 6'h09, 6'h12, 6'h1b, 6'h24, 6'h2d, 6'h36, 6'h3f, 6'h15};
  logic [3:0]   divs [9] = '{4'h2, 4'h3, 4'h4, 4'h6, 4'h8, 4'ha, 4'hc, 4'hc, 4'h2};

  adc_ctrl_regs uut (.clk(clk), .nrst(nrst), .ce(ce), .req(req), .rdata_ff(rdata_ff),
    .rvalid_ff(rvalid_ff), .base_rate_sel(base_rate_sel), .gain_step_rate_sel(gain_step_rate_sel),
    .frame_clock(frame_clock), .fmt_ff(fmt_ff), .left_ff(left_ff), .right_ff(right_ff),
    .bad_rate_ff(bad_rate_ff));

  // ----------
  // Helpers
  // ----------
  task automatic check(input logic [19:0] seen, input logic [19:0] exp);
    comparisons++;
    if (seen !== exp) begin
      mismatches++;
      $display("ERROR %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : check

  task automatic conclude;
    if (mismatches == 0 && comparisons > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask : conclude

  task automatic reg_wr(input logic [3:0] pg, input logic [5:0] ad, input logic [15:0] d);
    @(posedge clk);
    req <= '{wr: 1'b1, rd: 1'b0, page: pg, addr: ad, wdata: d};
    @(posedge clk);
    req.wr <= 1'b0;
  endtask : reg_wr

  // Answer latency is fixed at one edge, so no polling
  task automatic reg_rd(input logic [3:0] pg, input logic [5:0] ad, input logic [15:0] exp);
    @(posedge clk);
    req <= '{wr: 1'b0, rd: 1'b1, page: pg, addr: ad, wdata: 16'h0000};
    @(posedge clk);
    req.rd <= 1'b0;
    #1;
    check(rvalid_ff, 1'b1);
    check(rdata_ff, exp);
  endtask : reg_rd

  // Period long enough for the pin synchroniser to see each rise
  task automatic frames(input int n);
    repeat (n) begin
      @(posedge clk) frame_clock <= 1'b1;
      repeat (4) @(posedge clk);
      frame_clock <= 1'b0;
      repeat (4) @(posedge clk);
    end
    #1;
  endtask : frames

  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end

  initial begin
    repeat (20000) @(posedge clk);
    mismatches++;
    conclude();
  end

  initial begin
    logic [15:0] d;
    logic [1:0]  w;
    {nrst, ce, base_rate_sel, gain_step_rate_sel, frame_clock} = 5'h08;
    req = '0;
    mismatches = 0;
    comparisons = 0;
    repeat (6) @(posedge clk);
    nrst <= 1'b1;
    reg_rd(PAGE_AUDIO, OFS_FORMAT_RATE, 16'h0000);
    reg_rd(PAGE_AUDIO, OFS_RSVD_A, 16'hff00);
    reg_rd(PAGE_AUDIO, OFS_VOLUME, 16'hffff);
    reg_rd(PAGE_AUDIO, OFS_RSVD_B, 16'h8b00);
    check(left_ff.att_code, 7'h7f);
    for (int i = 0; i < 9; i++) begin
      w = i[1:0];
      d = {4'hf, w, ~w, 2'h3, codes[i]};
      reg_wr(PAGE_AUDIO, OFS_FORMAT_RATE, d);
      reg_rd(PAGE_AUDIO, OFS_FORMAT_RATE, d & 16'h0f3f);
      check(fmt_ff.sample_bits, (w == 2'h3) ? 6'h20 : 6'h10 + {2'h0, w, 2'h0});
      check(fmt_ff.frame_format, 2'(~w));
      check(fmt_ff.div_x2, divs[i]);
      check(bad_rate_ff, i == 8);
      if (i < 8) check(fmt_ff.sample_rate_hz, 20'h17700 / divs[i]);
    end
    reg_wr(PAGE_AUDIO, OFS_FORMAT_RATE, 16'h0000);
    base_rate_sel <= 1'b1;
    repeat (8) @(posedge clk);
    #1 check(fmt_ff.sample_rate_hz, 20'hac44);
    @(posedge clk) base_rate_sel <= 1'b0;
    repeat (8) @(posedge clk);
    #1 check(fmt_ff.sample_rate_hz, 20'hbb80);
    reg_wr(4'h1, OFS_FORMAT_RATE, 16'h0f3f);
    reg_wr(PAGE_AUDIO, OFS_RSVD_A, 16'h0000);
    reg_wr(PAGE_AUDIO, OFS_RSVD_B, 16'h8b00);
    reg_wr(PAGE_AUDIO, 6'h04, 16'h1234);
    reg_rd(PAGE_AUDIO, OFS_FORMAT_RATE, 16'h0000);
    reg_rd(PAGE_AUDIO, OFS_RSVD_A, 16'hff00);
    reg_rd(PAGE_AUDIO, OFS_RSVD_B, 16'h8b00);
    reg_rd(4'h1, OFS_VOLUME, 16'h0000);
    reg_rd(PAGE_AUDIO, 6'h04, 16'h0000);
    @(posedge clk) ce <= 1'b0;
    reg_wr(PAGE_AUDIO, OFS_VOLUME, 16'h0000);
    @(posedge clk) ce <= 1'b1;
    reg_rd(PAGE_AUDIO, OFS_VOLUME, 16'hffff);
    reg_wr(PAGE_AUDIO, OFS_VOLUME, 16'h0083);
    reg_rd(PAGE_AUDIO, OFS_VOLUME, 16'h0083);
    check(left_ff.mute, 1'b0);
    check(right_ff.mute, 1'b1);
    frames(5);
    check(left_ff.gain_steps, 8'h05);
    check(right_ff.gain_steps, 8'h03);
    check(right_ff.settled, 1'b1);
    check(left_ff.settled, 1'b0);
    @(posedge clk) gain_step_rate_sel <= 1'b1;
    repeat (4) @(posedge clk);
    frames(4);
    check(left_ff.gain_steps, 8'h07);
    conclude();
  end
endmodule : audio_dac_control_regs_tb_top
